// ==== hdl/acs_pkg.sv ====
// Package for the conversion sequencer: register map, fields, modes, timing.
// Assumes a plain register port with read data one cycle after the strobe.
package acs_pkg;
    localparam int RES_W = 10;
    localparam int CH_W = 5;
    localparam int NUM_CH = 24;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    // Register offsets (word index)
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_RESULT = 4'h1;
    localparam logic [3:0] OFS_INJ = 4'h2;
    localparam logic [3:0] OFS_TIMING = 4'h3;
    localparam logic [3:0] OFS_SCAN_LO = 4'h4;
    localparam logic [3:0] OFS_SCAN_HI = 4'h5;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h6;
    localparam logic [3:0] OFS_IRQ_EN = 4'h7;
    localparam logic [3:0] OFS_IRQ_CLR = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'h9;
    // Control register fields
    localparam int CTRL_CH_LSB = 0;
    localparam int CTRL_MODE_LSB = 5;
    localparam int CTRL_START = 7;
    localparam int CTRL_WAIT_RD = 8;
    localparam int CTRL_OVR_PROT = 9;
    localparam int CTRL_PORT_SEL = 10;
    localparam int CTRL_INJ_REQ = 11;
    localparam int CTRL_INJ_CH_LSB = 12;
    // Timing register fields: sample [7:0], convert [15:8]
    localparam int TIM_SMP_LSB = 0;
    localparam int TIM_CNV_LSB = 8;
    localparam logic [15:0] TIMING_RST = 16'h0404;
    // Interrupt bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_OVR = 1;
    localparam int IRQ_INJ = 2;
    localparam int IRQ_N = 3;
    // Calibration: worst case 40630 CPU cycles
    localparam int CAL_CYCLES = 40630;
    typedef enum logic [1:0] {
        ACS_M_SINGLE = 2'h0,
        ACS_M_CONT = 2'h1,
        ACS_M_SCAN = 2'h2,
        ACS_M_SCAN_CONT = 2'h3
    } acs_mode_t;
    typedef enum logic [5:0] {
        ACS_CAL = 6'h01,
        ACS_IDLE = 6'h02,
        ACS_SAMPLE = 6'h04,
        ACS_CONVERT = 6'h08,
        ACS_HOLD = 6'h10,
        ACS_NEXT = 6'h20
    } acs_state_t;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } acs_bus_t;
    typedef struct packed {
        logic [CH_W-1:0] ch;
        logic [RES_W-1:0] value;
    } acs_result_t;
endpackage

// ==== hdl/acs_sequencer.sv ====
// Conversion sequencer: calibration, four conversion modes, overrun handling,
// wait-for-read hold and injected conversions for a 10-bit converter.
// Assumes an analog core that samples on sample_en and delivers a result
// on cnv_value when the conversion interval ends.
// Summary of operation
// - Ten-bit results from 24 channels; one bit picks the extra port group.
// - Self-calibration runs after every reset before conversions are accepted.
// - Sample and conversion intervals are set by software.
// - Completion with unread previous result raises an overrun request unless a hold applies.
// - Optional protection holds the next conversion until result is read.
// - Channels not used for conversion stay usable as digital inputs.
// - Single mode converts selected channel once, stores result, stops.
// - Continuous mode converts selected channel repeatedly, storing each result.
// - Scan mode converts each selected channel once in order.
// - Scan continuous mode cycles through selected channels without end.
// - Every completed scan conversion signals an event for transfer.
// - Wait-for-read in a continuous mode buffers the new result and pauses until result read.
// - Injected channel converts between continuous conversions into second register.
// - After injection the continuous mode resumes; a scan restarts from its first channel.
// - Calibration finishes within 40630 CPU clock cycles.
// - Busy flag stays set for all of calibration, clears at end.
// - Calibration runs only after reset, never during operation.
module acs_sequencer
    import acs_pkg::*;
#(
    parameter int CAL_LEN = CAL_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Register port
    input wire acs_bus_t bus_in,
    output logic [DATA_W-1:0] rdata_q,
    // Analog core
    output logic sample_en,
    output logic [CH_W-1:0] mux_ch,
    output logic port_sel,
    input wire logic [RES_W-1:0] cnv_value,
    // Digital use of analog pins
    input wire logic [NUM_CH-1:0] pin_level,
    output logic [NUM_CH-1:0] digital_in,
    // Events
    output logic conv_event,
    output logic irq
);
    localparam int CAL_W = $clog2(CAL_LEN + 1);

    acs_state_t state_q;
    logic [15:0] ctrl_q;
    logic [15:0] timing_q;
    logic [NUM_CH-1:0] scan_q;
    logic [IRQ_N-1:0] stat_q, en_q;
    acs_result_t result_q, inj_q, temp_q;
    logic unread_q, temp_full_q, inj_active_q, inj_pend_q;
    logic [CAL_W-1:0] cal_cnt_q;
    logic [7:0] tcnt_q;
    logic [CH_W-1:0] cur_ch_q;
    logic busy;
    logic wr_ctrl, rd_result, done_pulse;
    logic [IRQ_N-1:0] set_ev;
    acs_mode_t mode;
    logic cont_mode, scan_mode, last_ch, hold_now;
    logic [CH_W-1:0] nxt_ch;

    assign mode = acs_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
    assign cont_mode = (mode == ACS_M_CONT) || (mode == ACS_M_SCAN_CONT);
    assign scan_mode = (mode == ACS_M_SCAN) || (mode == ACS_M_SCAN_CONT);
    assign busy = (state_q == ACS_CAL);
    assign wr_ctrl = bus_in.wr && (bus_in.addr == OFS_CTRL);
    assign rd_result = bus_in.rd && (bus_in.addr == OFS_RESULT);
    assign done_pulse = (state_q == ACS_CONVERT) && (tcnt_q == 8'h00);
    assign port_sel = ctrl_q[CTRL_PORT_SEL];
    assign sample_en = (state_q == ACS_SAMPLE);
    assign mux_ch = cur_ch_q;
    assign conv_event = done_pulse && !inj_active_q && scan_mode;
    assign irq = |(stat_q & en_q);
    // Hold when overrun protection, or wait-for-read in a continuous mode, finds an unread result
    assign hold_now = unread_q && (ctrl_q[CTRL_OVR_PROT] ||
                      (ctrl_q[CTRL_WAIT_RD] && cont_mode));

    // Digital reading of pins; a channel being sampled reads zero
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_dig
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    digital_in[gi] <= 1'b0;
                end else begin
                    digital_in[gi] <= pin_level[gi] &&
                        !(sample_en && (cur_ch_q == CH_W'(gi)));
                end
            end
        end
    endgenerate

    // Next selected scan channel, searching downward from the current one
    always_comb begin
        nxt_ch = cur_ch_q;
        last_ch = 1'b1;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (scan_q[i] && (CH_W'(i) < cur_ch_q)) begin
                nxt_ch = CH_W'(i);
                last_ch = 1'b0;
            end
        end
        // Loop picks the lowest; prefer the highest below current
        for (int i = 0; i < NUM_CH; i++) begin
            if (scan_q[i] && (CH_W'(i) < cur_ch_q)) begin
                nxt_ch = CH_W'(i);
            end
        end
    end

    // Software registers; the start bit clears itself once taken
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= 16'h0000;
            timing_q <= TIMING_RST;
            scan_q <= '0;
            en_q <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= bus_in.wdata;
            end else if (state_q == ACS_IDLE && ctrl_q[CTRL_START]) begin
                ctrl_q[CTRL_START] <= 1'b0;
            end
            if (inj_pend_q && state_q == ACS_NEXT) begin
                ctrl_q[CTRL_INJ_REQ] <= 1'b0;
            end
            if (bus_in.wr && bus_in.addr == OFS_TIMING) begin
                timing_q <= bus_in.wdata;
            end
            if (bus_in.wr && bus_in.addr == OFS_SCAN_LO) begin
                scan_q[15:0] <= bus_in.wdata;
            end
            if (bus_in.wr && bus_in.addr == OFS_SCAN_HI) begin
                scan_q[NUM_CH-1:16] <= bus_in.wdata[NUM_CH-17:0];
            end
            if (bus_in.wr && bus_in.addr == OFS_IRQ_EN) begin
                en_q <= bus_in.wdata[IRQ_N-1:0];
            end
        end
    end

    // Injection request counts as pending only while a continuous mode is selected
    assign inj_pend_q = ctrl_q[CTRL_INJ_REQ] && cont_mode;

    // Sequencer: calibration, sample, convert, hold, channel step
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ACS_CAL;
            cal_cnt_q <= '0;
            tcnt_q <= 8'h00;
            cur_ch_q <= '0;
            inj_active_q <= 1'b0;
        end else begin
            unique case (state_q)
                ACS_CAL: begin
                    cal_cnt_q <= cal_cnt_q + CAL_W'(1);
                    if (cal_cnt_q == CAL_W'(CAL_LEN - 1)) begin
                        state_q <= ACS_IDLE;
                    end
                end
                ACS_IDLE: begin
                    if (ctrl_q[CTRL_START]) begin
                        cur_ch_q <= ctrl_q[CTRL_CH_LSB +: CH_W];
                        tcnt_q <= timing_q[TIM_SMP_LSB +: 8];
                        state_q <= ACS_SAMPLE;
                    end
                end
                ACS_SAMPLE: begin
                    if (tcnt_q == 8'h00) begin
                        tcnt_q <= timing_q[TIM_CNV_LSB +: 8];
                        state_q <= ACS_CONVERT;
                    end else begin
                        tcnt_q <= tcnt_q - 8'h01;
                    end
                end
                ACS_CONVERT: begin
                    if (tcnt_q == 8'h00) begin
                        state_q <= (hold_now && !inj_active_q) ? ACS_HOLD : ACS_NEXT;
                    end else begin
                        tcnt_q <= tcnt_q - 8'h01;
                    end
                end
                ACS_HOLD: begin
                    if (!temp_full_q) begin
                        state_q <= ACS_NEXT;
                    end
                end
                ACS_NEXT: begin
                    tcnt_q <= timing_q[TIM_SMP_LSB +: 8];
                    if (inj_active_q) begin
                        inj_active_q <= 1'b0;
                        cur_ch_q <= ctrl_q[CTRL_CH_LSB +: CH_W];
                        state_q <= ACS_SAMPLE;
                    end else if (inj_pend_q) begin
                        inj_active_q <= 1'b1;
                        // Only four control bits remain, so injection reaches channels 0..15
                        cur_ch_q <= {1'b0, ctrl_q[CTRL_INJ_CH_LSB +: CH_W-1]};
                        state_q <= ACS_SAMPLE;
                    end else if (mode == ACS_M_SINGLE) begin
                        state_q <= ACS_IDLE;
                    end else if (mode == ACS_M_CONT) begin
                        state_q <= ACS_SAMPLE;
                    end else if (!last_ch) begin
                        cur_ch_q <= nxt_ch;
                        state_q <= ACS_SAMPLE;
                    end else if (mode == ACS_M_SCAN_CONT) begin
                        cur_ch_q <= ctrl_q[CTRL_CH_LSB +: CH_W];
                        state_q <= ACS_SAMPLE;
                    end else begin
                        state_q <= ACS_IDLE;
                    end
                end
                default: state_q <= ACS_CAL;
            endcase
        end
    end

    // Result registers; a held result waits in the temporary buffer
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            result_q <= '0;
            inj_q <= '0;
            temp_q <= '0;
            unread_q <= 1'b0;
            temp_full_q <= 1'b0;
        end else begin
            if (done_pulse && inj_active_q) begin
                inj_q <= '{ch: cur_ch_q, value: cnv_value};
            end else if (done_pulse && hold_now) begin
                temp_q <= '{ch: cur_ch_q, value: cnv_value};
                temp_full_q <= 1'b1;
            end else if (done_pulse) begin
                result_q <= '{ch: cur_ch_q, value: cnv_value};
            end
            // Read moves a buffered result up; the new result stays unread
            if (rd_result && temp_full_q) begin
                result_q <= temp_q;
                temp_full_q <= 1'b0;
            end
            if (done_pulse && !inj_active_q && !hold_now) begin
                unread_q <= 1'b1; // set wins over a read in the same cycle
            end else if (rd_result && !temp_full_q) begin
                unread_q <= 1'b0;
            end
        end
    end

    // Sticky status: set wins over a clear in the same cycle
    always_comb begin
        set_ev = '0;
        set_ev[IRQ_DONE] = done_pulse && !inj_active_q;
        set_ev[IRQ_OVR] = done_pulse && !inj_active_q && unread_q && !hold_now;
        set_ev[IRQ_INJ] = done_pulse && inj_active_q;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            stat_q <= '0;
        end else begin
            if (bus_in.wr && bus_in.addr == OFS_IRQ_CLR) begin
                stat_q <= (stat_q & ~bus_in.wdata[IRQ_N-1:0]) | set_ev;
            end else begin
                stat_q <= stat_q | set_ev;
            end
        end
    end

    // Read data stands one cycle after the read strobe; unmapped reads zero
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= '0;
        end else if (bus_in.rd) begin
            unique case (bus_in.addr)
                OFS_CTRL: rdata_q <= ctrl_q;
                OFS_RESULT: rdata_q <= 16'(result_q);
                OFS_INJ: rdata_q <= 16'(inj_q);
                OFS_TIMING: rdata_q <= timing_q;
                OFS_SCAN_LO: rdata_q <= scan_q[15:0];
                OFS_SCAN_HI: rdata_q <= 16'(scan_q[NUM_CH-1:16]);
                OFS_IRQ_STAT: rdata_q <= 16'(stat_q);
                OFS_IRQ_EN: rdata_q <= 16'(en_q);
                OFS_STATUS: rdata_q <= {13'h0000, temp_full_q, unread_q, busy};
                default: rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    AST_BUSY_CAL: assert property (@(posedge core_clk) disable iff (!rst_b)
        $fell(busy) |-> $past(cal_cnt_q) == CAL_W'(CAL_LEN - 1))
        else $error("busy cleared early");
    AST_NO_RECAL: assert property (@(posedge core_clk) disable iff (!rst_b)
        !busy |=> !busy)
        else $error("recalibration seen");
    AST_OVR_SET: assert property (@(posedge core_clk) disable iff (!rst_b)
        set_ev[IRQ_OVR] |=> stat_q[IRQ_OVR])
        else $error("overrun lost");
    AST_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b)
        state_q == ACS_HOLD && temp_full_q |=> state_q == ACS_HOLD)
        else $error("hold left while buffered");
    AST_SINGLE_STOP: assert property (@(posedge core_clk) disable iff (!rst_b)
        state_q == ACS_NEXT && mode == ACS_M_SINGLE && !inj_active_q && !inj_pend_q
        |=> state_q == ACS_IDLE)
        else $error("single mode kept running");
    AST_CONT_AGAIN: assert property (@(posedge core_clk) disable iff (!rst_b)
        state_q == ACS_NEXT && mode == ACS_M_CONT |=> state_q == ACS_SAMPLE)
        else $error("continuous stopped");
    AST_INJ_RESUME: assert property (@(posedge core_clk) disable iff (!rst_b)
        state_q == ACS_NEXT && inj_active_q |=> !inj_active_q && state_q == ACS_SAMPLE)
        else $error("no resume after inject");
    AST_EVENT: assert property (@(posedge core_clk) disable iff (!rst_b)
        conv_event |=> stat_q[IRQ_DONE])
        else $error("scan event lost");
endmodule

// ==== dv/acs_analog_model.sv ====
// Analog front end model: input multiplexer, sample-hold and converter core.
// Assumes sample_en stays high for the whole sampling interval.
module acs_analog_model
    import acs_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Sequencer side
    input wire logic sample_en,
    input wire logic [CH_W-1:0] mux_ch,
    input wire logic port_sel,
    output logic [RES_W-1:0] cnv_value
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [RES_W-1:0] held_q = 10'h000;
    logic [RES_W-1:0] junk_q = 10'h0AA;
    // Each channel and port group shows its own level, held once sampled
    always @(posedge core_clk) begin
        junk_q <= ~junk_q ^ 10'h155;
        if (sample_en) begin
            held_q <= {port_sel, mux_ch, 4'h9} ^ 10'h0C3;
        end
    end
    // Not settled while sampling, so a fetch too early sees a moving pattern
    assign cnv_value = sample_en ? junk_q : held_q;
endmodule

// ==== dv/adc_conversion_sequencer_tb.sv ====
// Self-checking bench for the conversion sequencer.
// Assumes the analog model in acs_analog_model and a shortened calibration.
module adc_conversion_sequencer_tb;
    import acs_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CAL_T = 20;
    localparam int LIMIT = 5000;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    acs_bus_t bus_in = '0;
    logic [DATA_W-1:0] rdata_q;
    logic sample_en;
    logic port_sel;
    logic conv_event;
    logic irq;
    logic [CH_W-1:0] mux_ch;
    logic [RES_W-1:0] cnv_value;
    logic [NUM_CH-1:0] pin_level = '0;
    logic [NUM_CH-1:0] digital_in;
    int n_mismatch = 0;
    int checks_done = 0;
    int n_smp = 0;
    int n_ev = 0;
    int smp_len = 0;
    int run_len = 0;
    int cyc = 0;
    logic [15:0] rnd = 16'hE496;
    logic [15:0] rv;

    acs_sequencer #(.CAL_LEN(CAL_T)) u_acs_sequencer (
        .core_clk(core_clk), .rst_b(rst_b), .bus_in(bus_in), .rdata_q(rdata_q),
        .sample_en(sample_en), .mux_ch(mux_ch), .port_sel(port_sel),
        .cnv_value(cnv_value), .pin_level(pin_level), .digital_in(digital_in),
        .conv_event(conv_event), .irq(irq));
    acs_analog_model u_acs_analog_model (
        .core_clk(core_clk), .sample_en(sample_en), .mux_ch(mux_ch),
        .port_sel(port_sel), .cnv_value(cnv_value));

    // Clock at 20 MHz
    always #25 core_clk = ~core_clk;

    // Counts sampling windows, their length and scan events; cuts a hang short
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        n_ev <= n_ev + int'(conv_event === 1'b1);
        run_len <= (sample_en === 1'b1) ? run_len + 1 : 0;
        if (sample_en === 1'b1 && run_len == 0) n_smp <= n_smp + 1;
        if (sample_en !== 1'b1 && run_len != 0) smp_len <= run_len;
        if (cyc == LIMIT) begin
            n_mismatch++;
            print_verdict();
        end
    end

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // Level the analog side presents for a channel and port group
    function automatic logic [RES_W-1:0] ana(input logic [CH_W-1:0] ch, input logic ps);
        return {ps, ch, 4'h9} ^ 10'h0C3;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Bounded wait, a stuck scan must not hang the run
    task automatic wait_ev(input int target);
        for (int i = 0; i < 100 && n_ev < target; i++) begin
            @(posedge core_clk);
            #1;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_in.wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge core_clk);
        bus_in <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_in.rd <= 1'b0;
        #1 d = rdata_q;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd(a, d);
        check(d, exp);
    endtask
    task automatic do_reset();
        logic [15:0] s;
        int polls;
        polls = 0;
        @(posedge core_clk);
        rst_b <= 1'b0;
        bus_in <= '0;
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(OFS_STATUS, s);
        check(s[0], 1'b1);
        // Software waits for busy to drop before any request
        while (s[0] !== 1'b0 && polls < CAL_T) begin
            check(sample_en, 1'b0);
            rd(OFS_STATUS, s);
            polls++;
        end
        check(32'(polls * 2 <= CAL_T + 4), 1);
        rd_chk(OFS_TIMING, TIMING_RST);
        wr(OFS_TIMING, 16'h0201);
    endtask

    // Main sequence
    initial begin
        logic [15:0] v;
        logic [CH_W-1:0] ch;
        int base;
        do_reset();
        rst_b <= 1'b0;
        do_reset();
        // Timing as set after reset, read-only and unmapped places
        rd_chk(OFS_TIMING, 16'h0201);
        wr(OFS_IRQ_STAT, 16'hFFFF);
        rd_chk(OFS_IRQ_STAT, 16'h0000);
        rd_chk(4'hF, 16'h0000);
        wr(OFS_TIMING, 16'h0201);
        // Random single conversions, top channel first
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            rv = rnd;
            ch = (i == 0) ? 5'd23 : 5'(rv[7:0] % NUM_CH);
            pin_level <= {rv[7:0], rv};
            wait_n(3);
            check(digital_in, pin_level);
            base = n_smp;
            wr(OFS_CTRL, 16'(ch) | (16'(rv[8]) << CTRL_PORT_SEL) | 16'h0080);
            wait_n(14);
            check(smp_len, 2);
            check(n_smp - base, 1);
            check(port_sel, rv[8]);
            rd_chk(OFS_RESULT, {1'b0, ch, ana(ch, rv[8])});
        end
        // Continuous on channel 7, left unread so it overruns
        wr(OFS_IRQ_EN, 16'h0002);
        wr(OFS_CTRL, 16'h00A7);
        wait_n(30);
        base = n_smp;
        wait_n(24);
        check(32'(n_smp - base >= 3), 1);
        rd(OFS_IRQ_STAT, v);
        check(v[IRQ_OVR], 1'b1);
        check(irq, 1'b1);
        wr(OFS_IRQ_EN, 16'h0000);
        wait_n(2);
        check(irq, 1'b0);
        rd_chk(OFS_RESULT, {1'b0, 5'd7, ana(5'd7, 1'b0)});
        // Overrun hold, then wait-for-read: conversion pauses until a read
        for (int k = 0; k < 2; k++) begin
            do_reset();
            wr(OFS_CTRL, 16'h00A4 | (16'h0100 << (1 - k)));
            wait_n(40);
            base = n_smp;
            wait_n(30);
            check(n_smp - base, 0);
            rd_chk(OFS_RESULT, {1'b0, 5'd4, ana(5'd4, 1'b0)});
            wait_n(30);
            check(32'(n_smp > base), 1);
        end
        // Single scan over channels 3 down to 0, with done interrupt
        do_reset();
        wr(OFS_SCAN_LO, 16'h000F);
        wr(OFS_IRQ_EN, 16'h0001);
        base = n_ev;
        wr(OFS_CTRL, 16'h00C3);
        for (int j = 3; j >= 0; j--) begin
            wait_ev(base + 4 - j);
            rd_chk(OFS_RESULT, {1'b0, 5'(j), ana(5'(j), 1'b0)});
        end
        wait_n(20);
        check(n_ev - base, 4);
        check(irq, 1'b1);
        wr(OFS_IRQ_CLR, 16'h0001);
        wait_n(2);
        check(irq, 1'b0);
        // Continuous scan, then an injected channel 9 in between
        do_reset();
        wr(OFS_SCAN_LO, 16'h0003);
        base = n_ev;
        wr(OFS_CTRL, 16'h00E1);
        wait_n(60);
        check(32'(n_ev - base > 4), 1);
        wr(OFS_CTRL, 16'h9861);
        wait_n(40);
        rd(OFS_INJ, v);
        check(v[RES_W-1:0], ana(5'd9, 1'b0));
        rd(OFS_IRQ_STAT, v);
        check(v[IRQ_INJ], 1'b1);
        base = n_ev;
        wait_n(40);
        check(32'(n_ev - base > 3), 1);
        rd(OFS_STATUS, v);
        check(v[0], 1'b0);
        print_verdict();
    end
endmodule
